// [src/fcp_pkg.sv]
// constants and types of the pause flow control block
// assumes one 10 MHz clock and byte wide frame streams
package fcp_pkg;

  // ----------------------------------------------------------------
  // clock and pause quantum timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int QUANTUM_NS_1G   = 512;
  localparam int QUANTUM_NS_100M = 5120;
  localparam int QUANTUM_NS_10M  = 51200;
  // least times, so round up
  localparam int QUANTUM_CYC_1G   =
    (QUANTUM_NS_1G + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUANTUM_CYC_100M =
    (QUANTUM_NS_100M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUANTUM_CYC_10M  =
    (QUANTUM_NS_10M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 10;

  localparam logic [1:0] SPEED_10M  = 2'h0;
  localparam logic [1:0] SPEED_100M = 2'h1;
  localparam logic [1:0] SPEED_1G   = 2'h2;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam logic [47:0] PAUSE_MCAST  = 48'h0180C2000001;
  localparam logic [15:0] CTRL_TYPE    = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [13:0] IDX_DA_LAST  = 14'h0005;
  localparam logic [13:0] IDX_SA_LAST  = 14'h000B;
  localparam logic [13:0] IDX_TYPE_HI  = 14'h000C;
  localparam logic [13:0] IDX_TYPE_LO  = 14'h000D;
  localparam logic [13:0] IDX_OP_HI    = 14'h000E;
  localparam logic [13:0] IDX_OP_LO    = 14'h000F;
  localparam logic [13:0] IDX_PARAM_HI = 14'h0010;
  localparam logic [13:0] IDX_PARAM_LO = 14'h0011;
  localparam logic [13:0] CTRL_FRAME_BYTES = 14'h0040;
  // generated frame without the fcs, which the mac core appends
  localparam logic [13:0] PAUSE_TX_LAST = 14'h003B;
  localparam logic [13:0] IDX_MAX       = 14'h3FFF;

  localparam int TX_STAT_PAUSE_BIT = 31;
  localparam int RX_STAT_CTRL_BIT  = 19;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_USER  = 3'b010,
    TX_PAUSE = 3'b100
  } fcp_tx_state_type;

endpackage

// [src/fcp_timer_if.sv]
// link between the flow control core and its pause timer
// assumes both ends share ref_clk
`timescale 1ns/1ps
interface fcp_timer_if;
  logic        load;
  logic [15:0] loadValue;
  logic [1:0]  speed;
  logic [15:0] remaining;
  logic        active;

  modport ctl (output load, output loadValue, output speed,
               input remaining, input active);
  modport tmr (input load, input loadValue, input speed,
               output remaining, output active);
endinterface

// [src/fcp_pause_timer.sv]
// pause timer: counts pause quanta down at the current link speed
// assumes load is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
module fcp_pause_timer (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  fcp_timer_if.tmr  tif
);

  logic [fcp_pkg::DIV_W-1:0] div_q;
  logic [fcp_pkg::DIV_W-1:0] divTop;
  logic [15:0]               remaining_q;
  logic                      quantumTick;

  assign divTop = (tif.speed == fcp_pkg::SPEED_1G) ?
      fcp_pkg::DIV_W'(fcp_pkg::QUANTUM_CYC_1G - 1) :
    (tif.speed == fcp_pkg::SPEED_100M) ?
      fcp_pkg::DIV_W'(fcp_pkg::QUANTUM_CYC_100M - 1) :
      fcp_pkg::DIV_W'(fcp_pkg::QUANTUM_CYC_10M - 1);
  assign quantumTick = (div_q >= divTop);
  assign tif.remaining = remaining_q;
  assign tif.active = (remaining_q != 16'h0000);

  // new frame restarts the quantum so it gets whole units
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || tif.load || quantumTick)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      remaining_q <= 16'h0000;
    else if (tif.load)
      remaining_q <= tif.loadValue;
    else if (tif.active && quantumTick)
      remaining_q <= remaining_q - 16'h0001;
  end

endmodule // fcp_pause_timer

// [src/fcp_pause_frame_gen.sv]
// byte source for a locally generated pause frame
// assumes the caller walks byteIndex from zero up to the last byte
`timescale 1ns/1ps
module fcp_pause_frame_gen (
  input  wire logic [13:0] byteIndex,
  input  wire logic [15:0] duration,
  input  wire logic [47:0] sourceAddress,
  output wire logic [7:0]  frameByte
);

  logic [47:0] daShift;
  logic [47:0] saShift;
  logic [7:0]  daByte;
  logic [7:0]  saByte;
  logic [3:0]  saIdx;

  // shift counts built by concatenation: a product would wrap at 4 bits
  assign saIdx   = byteIndex[3:0] - 4'h6;
  assign daShift = fcp_pkg::PAUSE_MCAST << {byteIndex[2:0], 3'h0};
  assign saShift = sourceAddress << {saIdx[2:0], 3'h0};
  assign daByte = daShift[47:40];
  assign saByte = saShift[47:40];

  // remainder of the frame is zero padding
  assign frameByte =
    (byteIndex <= fcp_pkg::IDX_DA_LAST)  ? daByte :
    (byteIndex <= fcp_pkg::IDX_SA_LAST)  ? saByte :
    (byteIndex == fcp_pkg::IDX_TYPE_HI)  ? fcp_pkg::CTRL_TYPE[15:8] :
    (byteIndex == fcp_pkg::IDX_TYPE_LO)  ? fcp_pkg::CTRL_TYPE[7:0] :
    (byteIndex == fcp_pkg::IDX_OP_HI)    ? fcp_pkg::PAUSE_OPCODE[15:8] :
    (byteIndex == fcp_pkg::IDX_OP_LO)    ? fcp_pkg::PAUSE_OPCODE[7:0] :
    (byteIndex == fcp_pkg::IDX_PARAM_HI) ? duration[15:8] :
    (byteIndex == fcp_pkg::IDX_PARAM_LO) ? duration[7:0] :
    8'h00;

endmodule // fcp_pause_frame_gen

// [src/fcp_flow_ctrl.sv]
// full duplex pause flow control: pause frame send, receive decode
// assumes all streams and controls are synchronous to ref_clk and
// that the downstream mac core appends preamble and fcs on transmit
`timescale 1ns/1ps

// Notes on behaviour
// - transmit and receive pause enabled independently
// - one pause quantum is 512 bit times
// - pause duration is 16-bit quantum count
// - frame uses multicast, own address, sampled duration
// - idle sends now, else after current frame
// - pause frame sent even while inhibited
// - one pending request, latest duration wins
// - fc disabled: user control frames pass through
// - control error-free needs checks and 64 bytes
// - failed control frames delivered with error flag
// - rx pause disabled: good control frames pass
// - match address, type code, then pause opcode
// - acceptable pause frame inhibits transmit for duration
// - inhibit by withholding transmit ready
// - acted pause frame delivered marked errored
// - length-checked wrong-size control frame marked errored
// - failed match: frame passed as good
// - control frames flagged on receive statistics bit 19
// - type 88-08 identifies a control frame
// - transmit statistics bit 31 marks sent pause
// - zero duration ends pause at once
module fcp_flow_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  speed,
  input  wire logic        txPauseEnable,
  input  wire logic        rxPauseEnable,
  input  wire logic        ctrlLengthCheck,
  input  wire logic [47:0] pauseAddress,
  input  wire logic        pauseRequest,
  input  wire logic [15:0] pauseDuration,
  input  wire logic [7:0]  txUserData,
  input  wire logic        txUserValid,
  input  wire logic        txUserLast,
  output wire logic        txUserReady,
  output wire logic [7:0]  txMacData,
  output wire logic        txMacValid,
  output wire logic        txMacLast,
  input  wire logic        txMacReady,
  output wire logic [31:0] txStatsVector,
  output wire logic        txStatsValid,
  input  wire logic [7:0]  rxInData,
  input  wire logic        rxInValid,
  input  wire logic        rxInLast,
  input  wire logic        rxInError,
  output wire logic [7:0]  rxOutData,
  output wire logic        rxOutValid,
  output wire logic        rxOutLast,
  output wire logic        rxOutUser,
  output wire logic [31:0] rxStatsVector,
  output wire logic        rxStatsValid,
  output wire logic        pauseActive
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] addrByte(input logic [47:0] addr,
                                          input logic [2:0]  idx);
    logic [47:0] shifted;
    shifted = addr << {idx, 3'h0};
    return shifted[47:40];
  endfunction

  function automatic logic [13:0] bumpIdx(input logic [13:0] idx);
    return (idx == fcp_pkg::IDX_MAX) ? idx : idx + 14'h0001;
  endfunction

  fcp_timer_if tif ();

  fcp_pause_timer u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tif     (tif)
  );

  // ----------------------------------------------------------------
  // transmit side
  // ----------------------------------------------------------------
  fcp_pkg::fcp_tx_state_type txState_q;
  fcp_pkg::fcp_tx_state_type txState_d;
  logic        pending_q;
  logic [15:0] pendVal_q;
  logic [15:0] sendVal_q;
  logic [13:0] txIdx_q;
  logic [7:0]  genByte;
  logic [7:0]  txData_q;
  logic        txValid_q;
  logic        txLast_q;
  logic [31:0] txStats_q;
  logic        txStatsValid_q;
  logic        outFree;
  logic        userBeat;
  logic        pauseBeat;
  logic        pauseDone;
  logic        userDone;
  logic        pauseStart;
  logic        userStart;
  logic        newRequest;

  fcp_pause_frame_gen u_gen (
    .byteIndex     (txIdx_q),
    .duration      (sendVal_q),
    .sourceAddress (pauseAddress),
    .frameByte     (genByte)
  );

  assign outFree    = !txValid_q || txMacReady;
  assign newRequest = pauseRequest && txPauseEnable;
  // pending pause goes first and ignores the inhibit
  assign pauseStart = (txState_q == fcp_pkg::TX_IDLE)
                      && pending_q;
  assign userStart  = (txState_q == fcp_pkg::TX_IDLE) && !pending_q
                      && txUserValid && !tif.active;
  assign userBeat   = (txState_q == fcp_pkg::TX_USER) && outFree
                      && txUserValid;
  assign pauseBeat  = (txState_q == fcp_pkg::TX_PAUSE) && outFree;
  assign userDone   = userBeat && txUserLast;
  assign pauseDone  = pauseBeat && (txIdx_q == fcp_pkg::PAUSE_TX_LAST);
  // user frames, control type or not, pass untouched
  assign txUserReady = (txState_q == fcp_pkg::TX_USER)
                       && outFree;

  assign txMacData     = txData_q;
  assign txMacValid    = txValid_q;
  assign txMacLast     = txLast_q;
  assign txStatsVector = txStats_q;
  assign txStatsValid  = txStatsValid_q;

  always_comb
  begin
    txState_d = txState_q;
    case (txState_q)
      fcp_pkg::TX_IDLE:
        if (pauseStart)
          txState_d = fcp_pkg::TX_PAUSE;
        else if (userStart)
          txState_d = fcp_pkg::TX_USER;
      fcp_pkg::TX_USER:
        if (userDone)
          txState_d = fcp_pkg::TX_IDLE;
      fcp_pkg::TX_PAUSE:
        if (pauseDone)
          txState_d = fcp_pkg::TX_IDLE;
      default:
        txState_d = fcp_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      txState_q <= fcp_pkg::TX_IDLE;
    else
      txState_q <= txState_d;
  end

  // a request in the start cycle wins and stays pending
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !txPauseEnable)
      pending_q <= 1'b0;
    else if (newRequest)
      pending_q <= 1'b1;
    else if (pauseStart)
      pending_q <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      pendVal_q <= 16'h0000;
    else if (newRequest)
      pendVal_q <= pauseDuration;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      sendVal_q <= 16'h0000;
    else if (pauseStart)
      sendVal_q <= pendVal_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || pauseStart)
      txIdx_q <= 14'h0000;
    else if (pauseBeat)
      txIdx_q <= bumpIdx(txIdx_q);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      txValid_q <= 1'b0;
      txData_q  <= 8'h00;
      txLast_q  <= 1'b0;
    end
    else if (outFree)
    begin
      txValid_q <= userBeat || pauseBeat;
      txData_q  <= pauseBeat ? genByte : txUserData;
      txLast_q  <= userDone || pauseDone;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      txStatsValid_q <= 1'b0;
      txStats_q      <= 32'h0000_0000;
    end
    else
    begin
      txStatsValid_q <= userDone || pauseDone;
      if (userDone || pauseDone)
      begin
        txStats_q <= 32'h0000_0000;
        txStats_q[fcp_pkg::TX_STAT_PAUSE_BIT] <= pauseDone;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive side
  // ----------------------------------------------------------------
  logic [13:0] rxIdx_q;
  logic        daMcast_q;
  logic        daOwn_q;
  logic [15:0] rxType_q;
  logic [15:0] rxOp_q;
  logic [15:0] rxParam_q;
  logic [13:0] rxLen;
  logic        rxEnd;
  logic        isCtrl;
  logic        lenOk;
  logic        ctrlBad;
  logic        isPause;
  logic        actPause;
  logic        errOut;
  logic [7:0]  rxData_q;
  logic        rxValid_q;
  logic        rxLast_q;
  logic        rxUser_q;
  logic [31:0] rxStats_q;
  logic        rxStatsValid_q;

  assign rxEnd  = rxInValid && rxInLast;
  assign rxLen  = bumpIdx(rxIdx_q);
  assign isCtrl = (rxType_q == fcp_pkg::CTRL_TYPE);
  assign lenOk  = ctrlLengthCheck ?
                  (rxLen == fcp_pkg::CTRL_FRAME_BYTES) :
                  (rxLen >= fcp_pkg::CTRL_FRAME_BYTES);
  // bad control frames are errored even with reception off
  assign ctrlBad  = isCtrl && (rxInError || !lenOk);
  assign isPause  = isCtrl && !ctrlBad && (daMcast_q || daOwn_q)
                    && (rxOp_q == fcp_pkg::PAUSE_OPCODE);
  assign actPause = rxEnd && isPause && rxPauseEnable;
  // anything else keeps its own error state
  assign errOut = rxInError || ctrlBad
                  || (isPause && rxPauseEnable);

  assign tif.load      = actPause;
  assign tif.loadValue = rxParam_q;
  assign tif.speed     = speed;
  assign pauseActive   = tif.active;

  assign rxOutData     = rxData_q;
  assign rxOutValid    = rxValid_q;
  assign rxOutLast     = rxLast_q;
  assign rxOutUser     = rxUser_q;
  assign rxStatsVector = rxStats_q;
  assign rxStatsValid  = rxStatsValid_q;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || rxEnd)
      rxIdx_q <= 14'h0000;
    else if (rxInValid)
      rxIdx_q <= bumpIdx(rxIdx_q);
  end

  // address match narrows byte by byte; a new frame starts clean
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || rxEnd)
    begin
      daMcast_q <= 1'b1;
      daOwn_q   <= 1'b1;
    end
    else if (rxInValid && rxIdx_q <= fcp_pkg::IDX_DA_LAST)
    begin
      daMcast_q <= daMcast_q && (rxInData
                   == addrByte(fcp_pkg::PAUSE_MCAST, rxIdx_q[2:0]));
      daOwn_q   <= daOwn_q && (rxInData
                   == addrByte(pauseAddress, rxIdx_q[2:0]));
    end
  end

  // frames of 14 bytes or fewer never complete the type field, so never look like control
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || rxEnd)
    begin
      rxType_q  <= 16'h0000;
      rxOp_q    <= 16'h0000;
      rxParam_q <= 16'h0000;
    end
    else if (rxInValid)
    begin
      if (rxIdx_q == fcp_pkg::IDX_TYPE_HI ||
          rxIdx_q == fcp_pkg::IDX_TYPE_LO)
        rxType_q <= {rxType_q[7:0], rxInData};
      if (rxIdx_q == fcp_pkg::IDX_OP_HI ||
          rxIdx_q == fcp_pkg::IDX_OP_LO)
        rxOp_q <= {rxOp_q[7:0], rxInData};
      if (rxIdx_q == fcp_pkg::IDX_PARAM_HI ||
          rxIdx_q == fcp_pkg::IDX_PARAM_LO)
        rxParam_q <= {rxParam_q[7:0], rxInData};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rxValid_q <= 1'b0;
      rxData_q  <= 8'h00;
      rxLast_q  <= 1'b0;
      rxUser_q  <= 1'b0;
    end
    else
    begin
      rxValid_q <= rxInValid;
      rxData_q  <= rxInData;
      rxLast_q  <= rxEnd;
      rxUser_q  <= rxEnd && errOut;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rxStatsValid_q <= 1'b0;
      rxStats_q      <= 32'h0000_0000;
    end
    else
    begin
      rxStatsValid_q <= rxEnd;
      if (rxEnd)
      begin
        rxStats_q <= 32'h0000_0000;
        rxStats_q[fcp_pkg::RX_STAT_CTRL_BIT] <= isCtrl;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence pause_due_s;
    txState_q == fcp_pkg::TX_IDLE && pending_q;
  endsequence

  sequence pause_begun_s;
    txState_q == fcp_pkg::TX_PAUSE && txIdx_q == 14'h0000
    && sendVal_q == $past(pendVal_q);
  endsequence

  req_latest_a: assert property (
    newRequest |=> pending_q && pendVal_q == $past(pauseDuration))
    else $error("pause request not held with latest duration");

  pause_first_a: assert property (
    pause_due_s |=> pause_begun_s)
    else $error("pending pause did not start from idle");

  pause_inhib_a: assert property (
    pause_due_s and tif.active |=> txState_q == fcp_pkg::TX_PAUSE)
    else $error("pause frame held back by inhibit");

  ready_held_a: assert property (
    tif.active && txState_q == fcp_pkg::TX_IDLE
    |-> !txUserReady ##1 txState_q != fcp_pkg::TX_USER)
    else $error("transmit ready given during pause");

  tx_disable_a: assert property (
    !txPauseEnable |=> !pending_q)
    else $error("pause request kept while transmit pause off");

  act_errored_a: assert property (
    actPause |=> rxLast_q && rxUser_q && tif.active
                 == ($past(rxParam_q) != 16'h0000))
    else $error("acted pause frame not errored or not loaded");

  bad_ctrl_a: assert property (
    rxEnd && isCtrl && ctrlLengthCheck
    && rxLen != fcp_pkg::CTRL_FRAME_BYTES
    |-> !actPause ##1 rxUser_q)
    else $error("wrong size control frame not errored");

  good_pass_a: assert property (
    rxEnd && !isCtrl && !rxInError |=> rxLast_q && !rxUser_q)
    else $error("non control frame marked errored");

  reload_timer_a: assert property (
    actPause |=> tif.remaining == $past(rxParam_q))
    else $error("pause timer not reloaded");

  zero_resume_a: assert property (
    actPause && rxParam_q == 16'h0000 |=> !pauseActive)
    else $error("zero pause did not end inhibit");

  ctrl_flag_a: assert property (
    rxEnd |=> rxStatsValid && rxStatsVector[fcp_pkg::RX_STAT_CTRL_BIT]
              == $past(isCtrl))
    else $error("control flag wrong in receive statistics");

  pause_stat_a: assert property (
    pauseDone |=> txStatsValid
                  && txStatsVector[fcp_pkg::TX_STAT_PAUSE_BIT])
    else $error("sent pause not flagged in transmit statistics");

endmodule // fcp_flow_ctrl

// [tb/fcp_mac_sink.sv]
// stand-in for the mac core behind the transmit output stage
// assumes bytes move on ref_clk rising edges with valid and ready high
`timescale 1ns/1ps
module fcp_mac_sink (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       stall,
  input  wire logic [7:0] txMacData,
  input  wire logic       txMacValid,
  input  wire logic       txMacLast,
  output logic            txMacReady
);
  logic [7:0] frameBytes [0:63];
  logic [7:0] firstByte [0:15];
  int         frameLen [0:15];
  int         frames;
  int         idx;
  logic       phase;

  initial
  begin
    txMacReady = 1'b0;
    phase = 1'b0;
    frames = 0;
    idx = 0;
  end

  // ----------------------------------------------------------------
  // ready and capture
  // ----------------------------------------------------------------
  // stall drops ready every other cycle so the held output is exercised
  always @(negedge ref_clk)
  begin
    phase <= ~phase;
    txMacReady <= rst_n & (~stall | phase);
  end

  always @(posedge ref_clk)
    if (txMacValid && txMacReady)
    begin
      if (idx < 64)
        frameBytes[idx] = txMacData;
      if (idx == 0)
        firstByte[frames[3:0]] = txMacData;
      idx = idx + 1;
      if (txMacLast)
      begin
        frameLen[frames[3:0]] = idx;
        frames = frames + 1;
        idx = 0;
      end
    end
endmodule // fcp_mac_sink

// [tb/tb_top.sv]
// self-checking bench for the pause flow control block
// assumes the mac core stand-in in fcp_mac_sink.sv
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, rst_n, txPauseEnable, rxPauseEnable, ctrlLengthCheck;
  logic pauseRequest, txUserValid, txUserLast, txMacReady, txUserReady;
  logic txMacValid, txMacLast, txStatsValid, rxInValid, rxInLast;
  logic rxInError, rxOutValid, rxOutLast, rxOutUser, rxStatsValid;
  logic pauseActive, stall;
  logic [1:0] speed;
  logic [47:0] pauseAddress;
  logic [15:0] pauseDuration;
  logic [7:0] txUserData, txMacData, rxInData, rxOutData;
  logic [31:0] txStatsVector, rxStatsVector, lastTxStats;
  logic [47:0] mcast = 48'h0180C2000001;
  int fail_count, n_checks, n, k, nf, q, bad;

  fcp_flow_ctrl fcp_flow_ctrl_inst (.ref_clk, .rst_n, .speed,
    .txPauseEnable, .rxPauseEnable, .ctrlLengthCheck, .pauseAddress,
    .pauseRequest, .pauseDuration, .txUserData, .txUserValid,
    .txUserLast, .txUserReady, .txMacData, .txMacValid, .txMacLast,
    .txMacReady, .txStatsVector, .txStatsValid, .rxInData, .rxInValid,
    .rxInLast, .rxInError, .rxOutData, .rxOutValid, .rxOutLast,
    .rxOutUser, .rxStatsVector, .rxStatsValid, .pauseActive);
  fcp_mac_sink fcp_mac_sink_inst (.ref_clk, .rst_n, .stall, .txMacData,
    .txMacValid, .txMacLast, .txMacReady);

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
    if (txStatsValid)
      lastTxStats <= txStatsVector;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic conclude;
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_frames(input int want);
    int i;
    for (i = 0; i < 400 && fcp_mac_sink_inst.frames < want; i++)
      @(negedge ref_clk);
    repeat (3) @(negedge ref_clk);
    if (fcp_mac_sink_inst.frames < want)
    begin
      chk("frame wait", 1, 0);
      conclude();
    end
  endtask

  task automatic request(input logic [15:0] dur);
    pauseRequest = 1'b1;
    pauseDuration = dur;
    @(negedge ref_clk);
    pauseRequest = 1'b0;
  endtask

  // bytes 12 and 13 carry the control type so user control frames pass
  task automatic tx_frame(input int len);
    int i, t;
    logic acc;
    i = 0;
    for (t = 0; t < 400 && i < len; t++)
    begin
      txUserData = (i == 12) ? 8'h88 : (i == 13) ? 8'h08 : 8'hA0 + i[7:0];
      txUserValid = 1'b1;
      txUserLast = (i == len - 1);
      #1 acc = txUserReady;
      @(negedge ref_clk);
      if (acc)
        i++;
    end
    txUserValid = 1'b0;
    txUserLast = 1'b0;
    if (i < len)
    begin
      chk("tx wait", 1, 0);
      conclude();
    end
  endtask

  task automatic rx_frame(input int len, input logic [47:0] da,
      input logic [15:0] op, prm, input logic err, expUser);
    int i;
    @(negedge ref_clk);
    for (i = 0; i < len; i++)
    begin
      rxInData = (i < 6) ? da[8*(5-i) +: 8] : (i < 12) ? 8'h5A
        : (i == 12) ? 8'h88 : (i == 13) ? 8'h08 : (i == 14) ? op[15:8]
        : (i == 15) ? op[7:0] : (i == 16) ? prm[15:8]
        : (i == 17) ? prm[7:0] : 8'h00;
      rxInValid = 1'b1;
      rxInLast = (i == len - 1);
      rxInError = err && (i == len - 1);
      @(negedge ref_clk);
      chk("rx data", {1'b1, rxInData}, {rxOutValid, rxOutData});
    end
    rxInValid = 1'b0;
    rxInLast = 1'b0;
    rxInError = 1'b0;
    chk("rx last", 1, rxOutLast);
    chk("rx user", expUser, rxOutUser);
    chk("rx ctrl stat", 1, rxStatsValid & rxStatsVector[19]);
  endtask

  task automatic check_pause(input logic [15:0] dur, input int idx);
    int i;
    logic [7:0] e;
    for (i = 0; i < 60; i++)
    begin
      e = (i < 6) ? mcast[8*(5-i) +: 8]
        : (i < 12) ? pauseAddress[8*(11-i) +: 8]
        : (i == 12) ? 8'h88 : (i == 13) ? 8'h08 : (i == 15) ? 8'h01
        : (i == 16) ? dur[15:8] : (i == 17) ? dur[7:0] : 8'h00;
      chk("pause byte", e, fcp_mac_sink_inst.frameBytes[i]);
    end
    chk("pause len", 60, fcp_mac_sink_inst.frameLen[idx]);
    chk("tx stat", 1, lastTxStats[31]);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n, pauseRequest, txUserValid, txUserLast, rxInValid} = 5'h00;
    {rxInLast, rxInError, stall, txUserData, rxInData} = 19'h00000;
    {txPauseEnable, rxPauseEnable, ctrlLengthCheck} = 3'h7;
    speed = 2'h2;
    pauseAddress = 48'h02AB00C0FFEE;
    pauseDuration = 16'h0000;
    fail_count = 0;
    n_checks = 0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("reset pause", 0, pauseActive);
    request(16'h1234);
    wait_frames(1);
    repeat (30) @(negedge ref_clk);
    chk("one frame", 1, fcp_mac_sink_inst.frames);
    check_pause(16'h1234, 0);
    stall = 1'b1;
    fork
      tx_frame(20);
      begin
        repeat (8) @(negedge ref_clk);
        pauseRequest = 1'b1;
        pauseDuration = 16'h0066;
        @(negedge ref_clk);
        pauseDuration = 16'h0077;
        @(negedge ref_clk);
        pauseRequest = 1'b0;
      end
    join
    wait_frames(3);
    chk("single frame", 3, fcp_mac_sink_inst.frames);
    chk("user first", 8'hA0, fcp_mac_sink_inst.firstByte[1]);
    chk("user len", 20, fcp_mac_sink_inst.frameLen[1]);
    check_pause(16'h0077, 2);
    stall = 1'b0;
    txPauseEnable = 1'b0;
    fork
      tx_frame(20);
      request(16'h0011);
    join
    wait_frames(4);
    repeat (30) @(negedge ref_clk);
    chk("no pause frame", 4, fcp_mac_sink_inst.frames);
    chk("ctrl type hi", 8'h88, fcp_mac_sink_inst.frameBytes[12]);
    chk("ctrl type lo", 8'h08, fcp_mac_sink_inst.frameBytes[13]);
    chk("ctrl len", 20, fcp_mac_sink_inst.frameLen[3]);
    txPauseEnable = 1'b1;
    nf = 4;
    for (k = 0; k < 3; k++)
    begin
      speed = (k == 0) ? 2'h2 : (k == 1) ? 2'h1 : 2'h0;
      q = (k == 0) ? 512 : (k == 1) ? 5120 : 51200;
      q = (q + 99) / 100;
      rx_frame(64, (k == 1) ? pauseAddress : mcast, 16'h0001, 16'h0002,
        1'b0, 1'b1);
      chk("pause on", 1, pauseActive);
      bad = 0;
      for (n = 0; n < 1100 && pauseActive; n++)
      begin
        txUserValid = 1'b1;
        txUserLast = 1'b1;
        @(negedge ref_clk);
        bad += (txUserReady & pauseActive);
      end
      chk("ready in pause", 0, bad);
      chk("pause length", 1, n >= 2 * q - 2 && n <= 2 * q + 2);
      tx_frame(1);
      nf++;
      wait_frames(nf);
    end
    speed = 2'h2;
    rx_frame(64, mcast, 16'h0001, 16'hFFFF, 1'b0, 1'b1);
    request(16'h0055);
    nf++;
    wait_frames(nf);
    chk("sent while held", 1, pauseActive);
    check_pause(16'h0055, nf - 1);
    rx_frame(64, mcast, 16'h0001, 16'h0001, 1'b0, 1'b1);
    for (n = 0; n < 40 && pauseActive; n++)
      @(negedge ref_clk);
    chk("reload", 1, n <= 8);
    rx_frame(64, mcast, 16'h0001, 16'hFFFF, 1'b0, 1'b1);
    rx_frame(64, mcast, 16'h0001, 16'h0000, 1'b0, 1'b1);
    chk("zero ends", 0, pauseActive);
    rx_frame(60, mcast, 16'h0001, 16'h0005, 1'b0, 1'b1);
    rx_frame(64, mcast, 16'h0001, 16'h0005, 1'b1, 1'b1);
    rx_frame(64, mcast + 48'h1, 16'h0001, 16'h0005, 1'b0, 1'b0);
    rx_frame(64, mcast, 16'h0002, 16'h0005, 1'b0, 1'b0);
    chk("no act", 0, pauseActive);
    rxPauseEnable = 1'b0;
    rx_frame(64, mcast, 16'h0001, 16'h0005, 1'b0, 1'b0);
    rx_frame(65, mcast, 16'h0001, 16'h0005, 1'b0, 1'b1);
    chk("rx disabled", 0, pauseActive);
    conclude();
  end
endmodule // tb_top
